// ==== design/dvi_fmt_pkg.sv ====
// Constants shared by the pixel output formatter and its helpers.
// Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
package dvi_fmt_pkg;
    // Clock and link timing
    localparam int CLK_PERIOD_NS   = 40;
    localparam int DE_IDLE_TIME_NS = 1000000;
    localparam int DE_IDLE_CYCLES  = DE_IDLE_TIME_NS / CLK_PERIOD_NS;
    localparam logic [1:0] OCK_EDGE_CYC = 2'h2;

    // Widths
    localparam int CH_W   = 8;
    localparam int PIX_W  = 24;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int SYNC_W = 32;

    // Register offsets
    localparam logic [ADDR_W-1:0] CTRL_ADDR       = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_ADDR     = 4'h4;
    localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 4'h8;
    localparam logic [ADDR_W-1:0] INT_MASK_ADDR   = 4'hc;

    // Control fields
    localparam int CTRL_W        = 3;
    localparam int CTRL_PIXELS_PER_CLOCK_SELECT_BIT = 0;
    localparam int CTRL_STAGGER_SELECT_N_BIT = 1;
    localparam int CTRL_POL_BIT  = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h6;

    // Status fields
    localparam int STATUS_W = 2;

    // Interrupt events
    localparam int INT_W    = 3;
    localparam int INT_UP   = 0;
    localparam int INT_DOWN = 1;
    localparam int INT_LINE = 2;
    localparam logic [INT_W-1:0] INT_RESET = 3'h0;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register index type
    typedef enum logic [2:0] {
        REG_CTRL, REG_STATUS, REG_INT_STATUS, REG_INT_MASK, REG_NONE
    } reg_sel_t;
endpackage

// ==== design/pin_sync.sv ====
// Two-flop synchroniser for a bundle of asynchronous input pins.
// Assumes each bit is stable long enough to be sampled by aclk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Pins in, synchronised out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] stage1;

    // First stage, read only by the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
        end else begin
            stage1 <= pin_in;
        end
    end

    // Second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= '0;
        end else begin
            pin_out <= stage1;
        end
    end
endmodule // pin_sync
`default_nettype wire

// ==== design/dvi_rx_pixel_output_formatter.sv ====
// Pixel output formatter: decoded link lanes to even/odd pixel buses.
// Assumes decoded lanes, DE and the link clock arrive as async pins.
`timescale 1ns/1ps
`default_nettype none
module dvi_rx_pixel_output_formatter
    import dvi_fmt_pkg::*;
#(
    parameter int DE_IDLE_CYC = dvi_fmt_pkg::DE_IDLE_CYCLES
) (
    // Clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite slave
    input  wire logic [dvi_fmt_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [dvi_fmt_pkg::DATA_W-1:0] wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    input  wire logic [dvi_fmt_pkg::ADDR_W-1:0] araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [dvi_fmt_pkg::DATA_W-1:0]     rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    // Decoded link lanes
    input  wire logic                          link_clock_pair,
    input  wire logic [dvi_fmt_pkg::CH_W-1:0]  link_lane_blue_data,
    input  wire logic [1:0]                    link_lane_blue_ctl,
    input  wire logic [dvi_fmt_pkg::CH_W-1:0]  link_lane_green_data,
    input  wire logic                          link_lane_green_ctl,
    input  wire logic [dvi_fmt_pkg::CH_W-1:0]  link_lane_red_data,
    input  wire logic [1:0]                    link_lane_red_ctl,
    input  wire logic                          link_de,
    // Output driver power-down pin
    input  wire logic                          output_drive_powerdown_n,
    // Pixel and control outputs
    output logic [dvi_fmt_pkg::PIX_W-1:0]      even_pixel_bus,
    output logic [dvi_fmt_pkg::PIX_W-1:0]      odd_pixel_bus,
    output logic                               de_out,
    output logic                               hsync,
    output logic                               vsync,
    output logic                               ctl1,
    output logic                               ctl2,
    output logic                               ctl3,
    output logic                               output_pixel_clock,
    output logic                               pixel_out_en,
    // Link status and interrupt
    output logic                               link_active_flag,
    output logic                               irq
);
    // Synchronised pins
    logic [SYNC_W-1:0] pins_s;
    logic              lclk_s;
    logic [CH_W-1:0]   blue_s;
    logic [1:0]        bctl_s;
    logic [CH_W-1:0]   green_s;
    logic              gctl_s;
    logic [CH_W-1:0]   red_s;
    logic [1:0]        rctl_s;
    logic              de_s;
    logic              pdo_s;

    pin_sync #(.W(SYNC_W)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  ({link_clock_pair, link_lane_blue_data, link_lane_blue_ctl,
                   link_lane_green_data, link_lane_green_ctl,
                   link_lane_red_data, link_lane_red_ctl, link_de,
                   output_drive_powerdown_n}),
        .pin_out (pins_s)
    );
    assign {lclk_s, blue_s, bctl_s, green_s, gctl_s, red_s, rctl_s, de_s,
            pdo_s} = pins_s;

    // Registers
    logic [CTRL_W-1:0] ctrl;
    logic [INT_W-1:0]  int_status;
    logic [INT_W-1:0]  int_mask;
    logic              mode2;
    logic              stagger_select_n_n;
    logic              pol;
    assign mode2  = ctrl[CTRL_PIXELS_PER_CLOCK_SELECT_BIT];
    assign stagger_select_n_n = ctrl[CTRL_STAGGER_SELECT_N_BIT];
    assign pol    = ctrl[CTRL_POL_BIT];

    // Register decode
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
        unique case (a)
            CTRL_ADDR:       decode = REG_CTRL;
            STATUS_ADDR:     decode = REG_STATUS;
            INT_STATUS_ADDR: decode = REG_INT_STATUS;
            INT_MASK_ADDR:   decode = REG_INT_MASK;
            default:         decode = REG_NONE;
        endcase
    endfunction

    // Link clock edge, sampled mid-pixel on its falling edge
    logic lclk_d;
    logic pix_stb;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lclk_d <= 1'b0;
        end else begin
            lclk_d <= lclk_s;
        end
    end
    assign pix_stb = lclk_d & ~lclk_s;

    // Pixel parity within a line
    logic              parity;
    logic              de_last;
    logic              this_odd;
    logic              line_start;
    logic              upd;
    logic              upd_d;
    logic [PIX_W-1:0]  cur_pix;
    logic [PIX_W-1:0]  even_hold;
    logic [PIX_W-1:0]  odd_stage;
    assign line_start = pix_stb & de_s & ~de_last;
    assign this_odd   = line_start ? 1'b0 : parity;
    assign upd        = pix_stb & (~mode2 | this_odd);
    assign cur_pix    = {red_s, green_s, blue_s};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            parity  <= 1'b0;
            de_last <= 1'b0;
        end else if (pix_stb) begin
            parity  <= ~this_odd;
            de_last <= de_s;
        end
    end

    // Pair holding for two-pixel mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            even_hold <= '0;
            odd_stage <= '0;
        end else if (pix_stb) begin
            if (mode2 && !this_odd) begin
                even_hold <= cur_pix;
            end
            if (upd) begin
                odd_stage <= mode2 ? cur_pix : '0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upd_d <= 1'b0;
        end else begin
            upd_d <= upd;
        end
    end

    // Even bus and controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            even_pixel_bus <= '0;
            de_out         <= 1'b0;
            hsync          <= 1'b0;
            vsync          <= 1'b0;
            ctl1           <= 1'b0;
            ctl2           <= 1'b0;
            ctl3           <= 1'b0;
        end else if (upd) begin
            even_pixel_bus <= mode2 ? even_hold : cur_pix;
            de_out         <= de_s;
            {vsync, hsync} <= bctl_s;
            ctl1           <= gctl_s;
            {ctl3, ctl2}   <= rctl_s;
        end
    end

    // Odd bus, same edge or one clock later when staggered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            odd_pixel_bus <= '0;
        end else if (upd && !mode2) begin
            odd_pixel_bus <= '0;
        end else if (upd && stagger_select_n_n) begin
            odd_pixel_bus <= cur_pix;
        end else if (upd_d && !stagger_select_n_n) begin
            odd_pixel_bus <= odd_stage;
        end
    end

    // Output pixel clock, capture edge after both buses settle
    logic [1:0] ock_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_pixel_clock <= 1'b0;
            ock_cnt            <= '0;
        end else if (upd) begin
            output_pixel_clock <= ~pol;
            ock_cnt            <= OCK_EDGE_CYC;
        end else if (ock_cnt == 2'h1) begin
            output_pixel_clock <= pol;
            ock_cnt            <= '0;
        end else if (ock_cnt != 2'h0) begin
            ock_cnt <= ock_cnt - 2'h1;
        end
    end

    // Output driver enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pixel_out_en <= 1'b0;
        end else begin
            pixel_out_en <= pdo_s;
        end
    end

    // DE activity watch
    logic        de_prev;
    logic [31:0] idle_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            de_prev          <= 1'b0;
            idle_cnt         <= '0;
            link_active_flag <= 1'b0;
        end else begin
            de_prev <= de_s;
            if (de_s != de_prev) begin
                idle_cnt         <= '0;
                link_active_flag <= 1'b1;
            end else if (idle_cnt >= 32'(DE_IDLE_CYC - 1)) begin
                link_active_flag <= 1'b0;
            end else begin
                idle_cnt <= idle_cnt + 32'h1;
            end
        end
    end

    // Interrupt events
    logic             active_d;
    logic [INT_W-1:0] ev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_d <= 1'b0;
        end else begin
            active_d <= link_active_flag;
        end
    end
    assign ev[INT_UP]   = link_active_flag & ~active_d;
    assign ev[INT_DOWN] = ~link_active_flag & active_d;
    assign ev[INT_LINE] = line_start;

    // AXI4-Lite write side
    logic [ADDR_W-1:0] aw_q;
    logic [DATA_W-1:0] w_q;
    logic [3:0]        ws_q;
    logic              aw_got;
    logic              w_got;
    logic              do_wr;
    reg_sel_t          wsel;
    assign do_wr = aw_got && w_got && !bvalid;
    assign wsel  = decode(aw_q);

    // Address and data held until the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            aw_q    <= '0;
            w_q     <= '0;
            ws_q    <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_q    <= awaddr;
                aw_got  <= 1'b1;
                awready <= 1'b0;
            end else if (!aw_got) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                w_q    <= wdata;
                ws_q   <= wstrb;
                w_got  <= 1'b1;
                wready <= 1'b0;
            end else if (!w_got) begin
                wready <= 1'b1;
            end
            if (do_wr) begin
                bvalid <= 1'b1;
                bresp  <= (wsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got  <= 1'b0;
            end
        end
    end

    // Control and mask registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl     <= CTRL_RESET;
            int_mask <= INT_RESET;
        end else if (do_wr && ws_q[0]) begin
            if (wsel == REG_CTRL) begin
                ctrl <= w_q[CTRL_W-1:0];
            end
            if (wsel == REG_INT_MASK) begin
                int_mask <= w_q[INT_W-1:0];
            end
        end
    end

    // Sticky status, a new event wins over a clear
    logic [INT_W-1:0] clr;
    assign clr = (do_wr && ws_q[0] && wsel == REG_INT_STATUS)
                 ? w_q[INT_W-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_status <= INT_RESET;
            irq        <= 1'b0;
        end else begin
            int_status <= (int_status & ~clr) | ev;
            irq        <= |(((int_status & ~clr) | ev) & int_mask);
        end
    end

    // AXI4-Lite read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= RESP_OKAY;
            unique case (decode(araddr))
                REG_CTRL:       rdata <= DATA_W'(ctrl);
                REG_STATUS:     rdata <= DATA_W'({pixel_out_en,
                                                  link_active_flag});
                REG_INT_STATUS: rdata <= DATA_W'(int_status);
                REG_INT_MASK:   rdata <= DATA_W'(int_mask);
                default: begin
                    rdata <= '0;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // Checks
    property p_odd_green_low;
        @(posedge aclk) disable iff (!aresetn)
        (upd && !mode2) |=> odd_pixel_bus[15:8] == 8'h00;
    endproperty
    a_odd_green_low: assert property (p_odd_green_low)
        else $error("odd green not low in one-pixel mode");

    property p_odd_red_low;
        @(posedge aclk) disable iff (!aresetn)
        (upd && !mode2) |=> odd_pixel_bus[23:16] == 8'h00;
    endproperty
    a_odd_red_low: assert property (p_odd_red_low)
        else $error("odd red not low in one-pixel mode");

    property p_even_blue_1pix;
        @(posedge aclk) disable iff (!aresetn)
        (pix_stb && !mode2) |=> even_pixel_bus[7:0] == $past(blue_s);
    endproperty
    a_even_blue_1pix: assert property (p_even_blue_1pix)
        else $error("even blue missed a one-pixel sample");

    property p_sync_recover;
        @(posedge aclk) disable iff (!aresetn)
        upd |=> {vsync, hsync} == $past(bctl_s) && ctl1 == $past(gctl_s);
    endproperty
    a_sync_recover: assert property (p_sync_recover)
        else $error("sync or ctl1 not recovered");

    property p_ctl_red;
        @(posedge aclk) disable iff (!aresetn)
        upd |=> {ctl3, ctl2} == $past(rctl_s);
    endproperty
    a_ctl_red: assert property (p_ctl_red)
        else $error("ctl2 or ctl3 not recovered");

    property p_active_on_toggle;
        @(posedge aclk) disable iff (!aresetn)
        (de_s != de_prev) |=> link_active_flag ##1 link_active_flag;
    endproperty
    a_active_on_toggle: assert property (p_active_on_toggle)
        else $error("link active flag missed a DE toggle");

    property p_stagger;
        @(posedge aclk) disable iff (!aresetn)
        (upd && mode2 && !stagger_select_n_n) |=> $stable(odd_pixel_bus)
            ##1 odd_pixel_bus == odd_stage;
    endproperty
    a_stagger: assert property (p_stagger)
        else $error("odd bus not staggered by one clock");

    property p_together;
        @(posedge aclk) disable iff (!aresetn)
        (upd && mode2 && stagger_select_n_n) |=> odd_pixel_bus == $past(cur_pix)
            && even_pixel_bus == $past(even_hold);
    endproperty
    a_together: assert property (p_together)
        else $error("even and odd buses not updated together");

    property p_capture_edge;
        @(posedge aclk) disable iff (!aresetn)
        upd |=> (output_pixel_clock == ~pol) [*2]
            ##1 output_pixel_clock == pol;
    endproperty
    a_capture_edge: assert property (p_capture_edge)
        else $error("capture edge misplaced after update");

    property p_line_even;
        @(posedge aclk) disable iff (!aresetn)
        (line_start && mode2) |-> !upd ##1 even_hold == $past(cur_pix);
    endproperty
    a_line_even: assert property (p_line_even)
        else $error("first pixel of a line not taken as even");

    property p_powerdown;
        @(posedge aclk) disable iff (!aresetn)
        !pdo_s |=> !pixel_out_en;
    endproperty
    a_powerdown: assert property (p_powerdown)
        else $error("outputs enabled during power-down");
endmodule // dvi_rx_pixel_output_formatter
`default_nettype wire

// ==== tb/dvi_tx_model.sv ====
// Link transmitter model: whole lines of 8 active and 4 blank pixels.
// Assumes run from the bench; the link clock stands still when idle.
`timescale 1ns/1ps
`default_nettype none
module dvi_tx_model (
    // Bench control
    input  wire logic       run,
    input  wire logic [7:0] base,
    // Decoded lanes
    output logic            link_clock_pair,
    output logic [7:0]      link_lane_blue_data,
    output logic [1:0]      link_lane_blue_ctl,
    output logic [7:0]      link_lane_green_data,
    output logic            link_lane_green_ctl,
    output logic [7:0]      link_lane_red_data,
    output logic [1:0]      link_lane_red_ctl,
    output logic            link_de
);
    logic [6:0] v;
    initial begin
        link_clock_pair = 1'b0;
        link_de = 1'b0;
        {link_lane_blue_ctl, link_lane_green_ctl, link_lane_red_ctl} = '0;
        {link_lane_blue_data, link_lane_green_data} = '0;
        link_lane_red_data = '0;
        forever begin
            wait (run === 1'b1);
            #13;
            for (int p = 0; p < 12; p++) begin
                link_clock_pair = 1'b1;
                link_de = p < 8;
                // Blank data flips its top bit and changes every pixel
                v = p < 8 ? 7'(base + 8'(p)) : 7'(p);
                link_lane_blue_data = {~link_de, v};
                link_lane_green_data = {~link_de, v ^ 7'h15};
                link_lane_red_data = {~link_de, v ^ 7'h2a};
                link_lane_blue_ctl = link_de ? 2'h0 : {p[1], ~p[1]};
                link_lane_green_ctl = ~link_de & p[1];
                link_lane_red_ctl = link_de ? 2'h0 : {~p[1], p[1]};
                #160 link_clock_pair = 1'b0;
                #160;
            end
        end
    end
endmodule // dvi_tx_model
`default_nettype wire

// ==== tb/dvi_rx_pixel_output_formatter_tb.sv ====
// Testbench: link model feeds lanes, bench scores pixel and register paths.
// Assumes the formatter package and a 25 MHz aclk.
`timescale 1ns/1ps
`default_nettype none
module dvi_rx_pixel_output_formatter_tb;
    import dvi_fmt_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run, chk;
    logic awready, wready, bvalid, arready, rvalid, de_out, hsync, vsync;
    logic ctl1, ctl2, ctl3, output_pixel_clock, pixel_out_en, irq;
    logic link_active_flag, link_clock_pair, link_lane_green_ctl, link_de;
    logic output_drive_powerdown_n, par, de_d, ech, pech;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, link_lane_blue_ctl, link_lane_red_ctl;
    logic [7:0]  link_lane_blue_data, link_lane_green_data;
    logic [7:0]  link_lane_red_data, base;
    logic [23:0] even_pixel_bus, odd_pixel_bus, ev, pe, po;
    logic [2:0]  mode;
    logic [2:0]  modes [4] = '{3'h6, 3'h2, 3'h7, 3'h5};
    logic [53:0] q [$];
    logic [53:0] e;
    int          num_errors, n_compared;

    dvi_rx_pixel_output_formatter #(.DE_IDLE_CYC(200))
        u_dvi_rx_pixel_output_formatter (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .link_clock_pair, .link_lane_blue_data, .link_lane_blue_ctl,
        .link_lane_green_data, .link_lane_green_ctl, .link_lane_red_data,
        .link_lane_red_ctl, .link_de, .output_drive_powerdown_n,
        .even_pixel_bus, .odd_pixel_bus, .de_out, .hsync, .vsync, .ctl1,
        .ctl2, .ctl3, .output_pixel_clock, .pixel_out_en, .link_active_flag,
        .irq);
    dvi_tx_model u_dvi_tx_model (.run, .base, .link_clock_pair,
        .link_lane_blue_data, .link_lane_blue_ctl, .link_lane_green_data,
        .link_lane_green_ctl, .link_lane_red_data, .link_lane_red_ctl,
        .link_de);

    always #20 aclk = ~aclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            pa = pa && awready !== 1'b1;
            pw = pw && wready !== 1'b1;
            awvalid <= pa;
            wvalid <= pw;
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        check(32'(bresp), 32'(RESP_OKAY));
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(rdata, d);
        check(32'(rresp), 32'(r));
    endtask

    // Expected output per captured pixel, or per pair in two-pixel mode
    always @(negedge link_clock_pair) begin
        if (link_de && !de_d) par = 1'b0;
        if (!mode[0])
            q.push_back({link_de, link_lane_blue_ctl, link_lane_green_ctl,
                link_lane_red_ctl[0], link_lane_red_ctl[1], 24'h0,
                link_lane_red_data, link_lane_green_data, link_lane_blue_data});
        else if (par)
            q.push_back({link_de, link_lane_blue_ctl, link_lane_green_ctl,
                link_lane_red_ctl[0], link_lane_red_ctl[1], link_lane_red_data,
                link_lane_green_data, link_lane_blue_data, ev});
        ev = {link_lane_red_data, link_lane_green_data, link_lane_blue_data};
        par = ~par;
        de_d = link_de;
    end

    // Score at each capture edge of the output clock
    always @(output_pixel_clock) begin
        if (chk && output_pixel_clock === mode[2]) begin
            e = q.pop_front();
            check(32'({de_out, vsync, hsync, ctl1, ctl2, ctl3}),
                  32'(e[53:48]));
            if (e[53]) begin
                check(32'(even_pixel_bus), 32'(e[23:0]));
                check(32'(odd_pixel_bus), 32'(e[47:24]));
            end
        end
    end

    // Odd bus moves with even bus, or one cycle after it when staggered
    always @(posedge aclk) begin
        ech = even_pixel_bus !== pe;
        if (chk && mode[0] && odd_pixel_bus !== po)
            check({ech, mode[1] | pech}, {mode[1], 1'b1});
        pech = ech;
        pe = even_pixel_bus;
        po = odd_pixel_bus;
    end

    initial begin
        #400000;
        num_errors++;
        final_report();
    end

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, run, chk} = '0;
        {awaddr, araddr, wdata, base, ev, pe, po} = '0;
        {par, de_d, pech} = '0;
        output_drive_powerdown_n = 1'b1;
        mode = 3'h6;
        void'($urandom(32'h16b7442b));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk = 1'b1;
        rd(CTRL_ADDR, 32'(CTRL_RESET), RESP_OKAY);
        rd(INT_MASK_ADDR, 32'h0, RESP_OKAY);
        rd(4'h2, 32'h0, RESP_SLVERR);
        foreach (modes[i]) begin
            mode = modes[i];
            wr(CTRL_ADDR, 32'(modes[i]));
            base <= 8'($urandom);
            run <= 1'b1;
            repeat (150) @(posedge aclk);
            run <= 1'b0;
            rd(STATUS_ADDR, 32'h3, RESP_OKAY);
            repeat (400) @(posedge aclk);
            check(q.size(), 0);
            rd(STATUS_ADDR, 32'h2, RESP_OKAY);
        end
        check(32'(irq), 32'h0);
        wr(INT_MASK_ADDR, 32'h2);
        @(posedge aclk);
        check(32'(irq), 32'h1);
        rd(INT_STATUS_ADDR, 32'h7, RESP_OKAY);
        wr(INT_STATUS_ADDR, 32'h7);
        rd(INT_STATUS_ADDR, 32'h0, RESP_OKAY);
        check(32'(irq), 32'h0);
        output_drive_powerdown_n <= 1'b0;
        repeat (6) @(posedge aclk);
        check(32'(pixel_out_en), 32'h0);
        output_drive_powerdown_n <= 1'b1;
        repeat (6) @(posedge aclk);
        check(32'(pixel_out_en), 32'h1);
        output_drive_powerdown_n <= link_active_flag;
        repeat (6) @(posedge aclk);
        check(32'(pixel_out_en), 32'h0);
        final_report();
    end
endmodule // dvi_rx_pixel_output_formatter_tb
`default_nettype wire
